/* File: ccrr_ctrl.sv */
/*
 * core clock ratio and reset controller: synchronises the asynchronous
 * reset inputs, latches the ratio straps during reset, waits for pll lock,
 * then reports reset complete; output drivers are gated off in reset, pad_oe also on drive-off.
 * assumes the pll and pad ring sit outside; the clock is the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ccrr_ctrl
#(
   parameter int LOCK_CYC = ccrr_pkg::CCRR_LOCK_CYC
)
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   // pins from the board, asynchronous
   input  wire logic                 rst_in_n,
   input  wire logic [2:0]           clock_ratio_straps,
   input  wire logic                 dram_por_in,
   input  wire logic                 drive_off_req,
   // pll feedback and debug requests, same clock domain
   input  wire logic                 pll_locked,
   input  wire logic                 debug_halt_req,
   input  wire logic                 debug_done,
   // pins to the board
   output logic                      rst_out,
   output logic                      rst_out_oe,
   output logic                      pad_oe,
   // toward pll and core
   output ccrr_pkg::ccrr_pll_s       pll,
   output ccrr_pkg::ccrr_core_s      core,
   output logic                      dram_reset
);
   import ccrr_pkg::*;

   logic [1:0]            rst_meta_reg;
   logic [2:0]            strap_meta_reg;
   logic [2:0]            strap_sync_reg;
   logic [1:0]            por_meta_reg;
   logic [1:0]            drv_meta_reg;
   logic [CCRR_CNT_W-1:0] cnt_reg;
   logic [CCRR_CNT_W-1:0] cnt_next;
   ccrr_state_e           state_reg;
   ccrr_state_e           state_next;
   logic [3:0]            mult_reg;
   logic                  bad_reg;
   logic                  half_reg;

   // synchronised levels come only from the second stage
   wire                   rst_in_s  = ~rst_meta_reg[1];
   wire                   por_s     = por_meta_reg[1];
   wire                   drv_off_s = drv_meta_reg[1];
   wire                   in_reset  = srst | rst_in_s;

   // strap decode
   logic [3:0]            mult_dec;
   always_comb
   begin
      unique case (strap_sync_reg)
         3'h0:    mult_dec = CCRR_MULT_000;
         3'h1:    mult_dec = CCRR_MULT_001;
         3'h2:    mult_dec = CCRR_MULT_010;
         3'h3:    mult_dec = CCRR_MULT_011;
         3'h4:    mult_dec = CCRR_MULT_100;
         3'h5:    mult_dec = CCRR_MULT_101;
         3'h6:    mult_dec = CCRR_MULT_110;
         default: mult_dec = CCRR_MULT_DEFAULT;
      endcase
   end
   wire strap_bad = (strap_sync_reg == CCRR_STRAP_RSVD);

   wire lock_done = (cnt_reg >= CCRR_CNT_W'(LOCK_CYC - 1));

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = '0;
      unique case (state_reg)
         CCRR_ST_RESET:
            if (!in_reset)
               state_next = CCRR_ST_LOCK;
         CCRR_ST_LOCK:
         begin
            cnt_next = lock_done ? cnt_reg : cnt_reg + 1'b1;
            if (pll_locked && lock_done)
               state_next = CCRR_ST_RUN;
         end
         CCRR_ST_RUN:
            if (debug_halt_req)
               state_next = CCRR_ST_HALT;
         CCRR_ST_HALT:
            if (debug_done)
               state_next = CCRR_ST_RUN;
         default:
            state_next = CCRR_ST_RESET;
      endcase
      if (in_reset)
         state_next = CCRR_ST_RESET;
   end

   // two flip-flop synchronisers on every pin input
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rst_meta_reg   <= 2'h0;
         strap_meta_reg <= CCRR_STRAP_RESET;
         strap_sync_reg <= CCRR_STRAP_RESET;
         por_meta_reg   <= 2'h0;
         drv_meta_reg   <= 2'h0;
      end
      else
      begin
         rst_meta_reg   <= {rst_meta_reg[0], rst_in_n};
         strap_meta_reg <= clock_ratio_straps;
         strap_sync_reg <= strap_meta_reg;
         por_meta_reg   <= {por_meta_reg[0], dram_por_in};
         drv_meta_reg   <= {drv_meta_reg[0], drive_off_req};
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg <= CCRR_ST_RESET;
         cnt_reg   <= '0;
         mult_reg  <= CCRR_MULT_RESET;
         bad_reg   <= 1'b0;
         half_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         half_reg  <= (state_reg == CCRR_ST_RUN) ? ~half_reg : 1'b0;
         if (rst_in_s)
         begin
            mult_reg <= mult_dec;
            bad_reg  <= strap_bad;
         end
      end
   end

   // registered outputs
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rst_out          <= 1'b0;
         rst_out_oe       <= 1'b0;
         pad_oe           <= 1'b0;
         pll              <= '0;
         core             <= '{core_reset: 1'b1, default: 1'b0};
         dram_reset       <= 1'b1;
      end
      else
      begin
         rst_out          <= (state_next == CCRR_ST_RUN) ||
                             (state_next == CCRR_ST_HALT);
         rst_out_oe       <= ~in_reset;
         pad_oe           <= ~in_reset & ~drv_off_s;
         pll.mult         <= rst_in_s ? mult_dec : mult_reg;
         pll.ratio_bad    <= rst_in_s ? strap_bad : bad_reg;
         pll.pll_enable   <= ~srst;
         core.core_reset  <= (state_next == CCRR_ST_RESET) ||
                             (state_next == CCRR_ST_LOCK);
         core.core_run    <= (state_next == CCRR_ST_RUN);
         core.debug_ready <= (state_next == CCRR_ST_HALT);
         core.bus_clk_en  <= (state_reg == CCRR_ST_RUN) && !half_reg;
         dram_reset       <= ~por_s;
      end
   end

   // checks
   reset_tristate_a: assert property (@(posedge clk) disable iff (srst)
      rst_in_s |=> !pad_oe && !rst_out_oe)
      else $error("pads driven during reset");
   drive_off_a: assert property (@(posedge clk) disable iff (srst)
      drv_off_s |=> !pad_oe)
      else $error("pads driven while drive-off requested");
   strap_map_a: assert property (@(posedge clk) disable iff (srst)
      (rst_in_s && strap_sync_reg == 3'h5) |=> pll.mult == 4'hA)
      else $error("strap 101 not decoded to 10");
   strap_hold_a: assert property (@(posedge clk) disable iff (srst)
      (!rst_in_s && !$past(rst_in_s)) |-> $stable(mult_reg))
      else $error("multiplier changed outside reset");
   reset_idle_a: assert property (@(posedge clk) disable iff (srst)
      rst_in_s |=> core.core_reset && !core.core_run)
      else $error("core not idle in reset");
   done_lock_a: assert property (@(posedge clk) disable iff (srst)
      $rose(rst_out) |-> $past(pll_locked))
      else $error("reset complete before lock");
   done_out_a: assert property (@(posedge clk) disable iff (srst)
      rst_out |-> !core.core_reset)
      else $error("reset complete while core held");
   halt_only_a: assert property (@(posedge clk) disable iff (srst)
      (state_reg == CCRR_ST_HALT && debug_done && !in_reset) |=> core.core_run)
      else $error("no resume after debug");
   dram_por_a: assert property (@(posedge clk) disable iff (srst)
      por_s |=> !dram_reset)
      else $error("dram reset not released");
   half_rate_a: assert property (@(posedge clk) disable iff (srst)
      (core.bus_clk_en && state_reg == CCRR_ST_RUN) |=> !core.bus_clk_en)
      else $error("bus enable not half rate");
   lock_time_a: assert property (@(posedge clk) disable iff (srst)
      (state_reg == CCRR_ST_LOCK && !lock_done) |=> !rst_out)
      else $error("lock wait cut short");

   run_c:     cover property (@(posedge clk) disable iff (srst) $rose(rst_out));
   halt_c:    cover property (@(posedge clk) disable iff (srst) $rose(core.debug_ready));
   drvoff_c:  cover property (@(posedge clk) disable iff (srst) rst_out && !pad_oe);
   rsvd_c:    cover property (@(posedge clk) disable iff (srst) pll.ratio_bad);

endmodule

`default_nettype wire

/* File: ccrr_pkg.sv */
/*
 * package for the core clock ratio and reset controller: strap decode,
 * reset sequencing counts and the structs that group the block's pins.
 * assumes a single clk domain at 10 MHz with synchronous srst.
 */
`default_nettype none
package ccrr_pkg;

   localparam int          CCRR_CLK_PERIOD_NS = 100;
   // reset stretch time after the reset input drops; ccrr_ctrl does not use it
   localparam int          CCRR_RST_STRETCH_NS = 1000;
   localparam int          CCRR_RST_STRETCH_CYC =
      (CCRR_RST_STRETCH_NS + CCRR_CLK_PERIOD_NS - 1) / CCRR_CLK_PERIOD_NS;
   // phase-locked loop lock time, as a cycle count
   localparam int          CCRR_LOCK_NS = 2000;
   localparam int          CCRR_LOCK_CYC =
      (CCRR_LOCK_NS + CCRR_CLK_PERIOD_NS - 1) / CCRR_CLK_PERIOD_NS;
   localparam int          CCRR_CNT_W = 8;

   localparam logic [2:0]  CCRR_STRAP_RESET = 3'h0;
   localparam logic [2:0]  CCRR_STRAP_RSVD  = 3'h7;
   localparam logic [3:0]  CCRR_MULT_RESET  = 4'h4;
   localparam logic [3:0]  CCRR_MULT_DEFAULT = 4'h4;

   // strap decode table: code -> multiplier
   localparam logic [3:0]  CCRR_MULT_000 = 4'h4;
   localparam logic [3:0]  CCRR_MULT_001 = 4'h5;
   localparam logic [3:0]  CCRR_MULT_010 = 4'h6;
   localparam logic [3:0]  CCRR_MULT_011 = 4'h7;
   localparam logic [3:0]  CCRR_MULT_100 = 4'h8;
   localparam logic [3:0]  CCRR_MULT_101 = 4'hA;
   localparam logic [3:0]  CCRR_MULT_110 = 4'hC;

   typedef enum logic [3:0] {
      CCRR_ST_RESET = 4'b0001,
      CCRR_ST_LOCK  = 4'b0010,
      CCRR_ST_RUN   = 4'b0100,
      CCRR_ST_HALT  = 4'b1000
   } ccrr_state_e;

   // clock-setting outputs toward the phase-locked loop
   typedef struct packed {
      logic [3:0] mult;
      logic       ratio_bad;
      logic       pll_enable;
   } ccrr_pll_s;

   // status toward the core
   typedef struct packed {
      logic       core_reset;
      logic       core_run;
      logic       debug_ready;
      logic       bus_clk_en;
   } ccrr_core_s;

endpackage
`default_nettype wire

/* File: ccrr_board.sv */
/* board model: reset pin with minimum low time, ratio straps, pll lock.
 * assumes the bench steers release, lock and strap values on clk. */
`timescale 1ns/1ps
`default_nettype none
module ccrr_board
#(
   parameter int MIN_RST = 4
)
(
   // clock and steering from the bench
   input  wire logic                 clk,
   input  wire logic                 hold_rst,
   input  wire logic                 hold_lock,
   input  wire logic [2:0]           strap_set,
   // from the device
   input  wire ccrr_pkg::ccrr_pll_s  pll,
   input  wire logic                 rst_out,
   input  wire logic                 rst_out_oe,
   // to the device
   output logic                      rst_in_n,
   output logic [2:0]                clock_ratio_straps,
   output logic                      pll_locked,
   output logic                      dram_por_in
);
   import ccrr_pkg::*;
   int unsigned low_cyc = 0;
   logic        rst_n_reg = 1'b0;
   logic        lock_reg = 1'b0;
   always @(posedge clk)
   begin
      low_cyc <= rst_n_reg ? 0 : low_cyc + 1;
      rst_n_reg <= !(hold_rst || (!rst_n_reg && low_cyc < MIN_RST));
      lock_reg <= pll.pll_enable && !hold_lock;
   end
   assign rst_in_n = rst_n_reg;
   assign pll_locked = lock_reg;
   assign clock_ratio_straps = strap_set;
   // por line pulled low while the reset-output pad floats
   assign dram_por_in = rst_out_oe ? rst_out : 1'b0;
endmodule
`default_nettype wire

/* File: tb.sv */
/* testbench for the ratio and reset controller.
 * assumes ccrr_board stands in for reset supervisor and pll. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ccrr_pkg::*;
   logic       clk = 1'b0, srst = 1'b1, hold_rst = 1'b1, hold_lock = 1'b0;
   logic [2:0] strap_set = 3'h0;
   logic       drive_off_req = 1'b0, debug_halt_req = 1'b0, debug_done = 1'b0;
   logic       rst_in_n, pll_locked, dram_por_in, rst_out, rst_out_oe, pad_oe, dram_reset;
   logic [2:0] clock_ratio_straps;
   ccrr_pll_s  pll;
   ccrr_core_s core;
   int         miscompares = 0, total_checks = 0;
   ccrr_ctrl #(.LOCK_CYC(2)) ccrr_ctrl_i (.clk(clk), .srst(srst), .rst_in_n(rst_in_n),
      .clock_ratio_straps(clock_ratio_straps), .dram_por_in(dram_por_in),
      .drive_off_req(drive_off_req), .pll_locked(pll_locked),
      .debug_halt_req(debug_halt_req), .debug_done(debug_done), .rst_out(rst_out),
      .rst_out_oe(rst_out_oe), .pad_oe(pad_oe), .pll(pll), .core(core),
      .dram_reset(dram_reset));
   ccrr_board ccrr_board_i (.clk(clk), .hold_rst(hold_rst), .hold_lock(hold_lock),
      .strap_set(strap_set), .pll(pll), .rst_out(rst_out), .rst_out_oe(rst_out_oe),
      .rst_in_n(rst_in_n), .clock_ratio_straps(clock_ratio_straps),
      .pll_locked(pll_locked), .dram_por_in(dram_por_in));
   initial
      forever #50 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic test_done();
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // pull reset with a strap code, release it and wait for reset complete
   task automatic boot(input logic [2:0] code, input logic late);
      int i;
      hold_rst = 1'b1;
      cyc(4);
      strap_set = code;
      cyc(4);
      chk({rst_out_oe, pad_oe, core.core_reset, core.core_run}, 8'h2);
      hold_lock = late;
      hold_rst = 1'b0;
      if (late)
      begin
         cyc(12);
         chk(rst_out, 8'h0);
         hold_lock = 1'b0;
      end
      i = 0;
      while (rst_out !== 1'b1 && i < 30)
      begin
         cyc(1);
         i++;
      end
      // dram reset follows the reset-complete pin through its own synchroniser
      cyc(3);
      chk({rst_out, core.core_reset, core.core_run, dram_reset, pll.pll_enable},
          8'h15);
   endtask
   task automatic test_straps();
      logic [3:0] m [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'h4};
      for (int c = 0; c < 8; c++)
      begin
         boot(3'(c), 1'b0);
         chk({pll.mult, 3'h0, pll.ratio_bad}, {m[c], 3'h0, c == 7});
      end
      $display("test straps done");
   endtask
   task automatic test_lock_and_straps();
      boot(3'h3, 1'b1);
      strap_set = 3'h6;
      cyc(6);
      chk(pll.mult, 8'h7);
      $display("test late lock done");
   endtask
   task automatic test_drive_off();
      drive_off_req = 1'b1;
      cyc(1);
      chk(pad_oe, 8'h1);
      cyc(3);
      chk(pad_oe, 8'h0);
      drive_off_req = 1'b0;
      cyc(4);
      chk(pad_oe, 8'h1);
      $display("test drive off done");
   endtask
   task automatic test_debug();
      logic b;
      b = core.bus_clk_en;
      cyc(1);
      chk(core.bus_clk_en, !b);
      debug_halt_req = 1'b1;
      cyc(1);
      debug_halt_req = 1'b0;
      cyc(2);
      chk({core.debug_ready, core.core_run}, 8'h2);
      debug_done = 1'b1;
      cyc(1);
      debug_done = 1'b0;
      cyc(2);
      chk({core.debug_ready, core.core_run}, 8'h1);
      srst = 1'b1;
      cyc(2);
      chk({rst_out, rst_out_oe, pad_oe, dram_reset, core.core_reset}, 8'h3);
      srst = 1'b0;
      cyc(8);
      chk(rst_out, 8'h1);
      $display("test debug and reset done");
   endtask
   initial
   begin
      cyc(8);
      srst = 1'b0;
      test_straps();
      test_lock_and_straps();
      test_drive_off();
      test_debug();
      test_done();
   end
   initial
   begin
      #400000;
      miscompares++;
      test_done();
   end
endmodule
`default_nettype wire
